/* verification/testbench.sv */
// self-checking bench of the window watchdog supervisor
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// signals
	localparam int UP = 128; // shortened upper window
	localparam int DP = 64;  // shortened pullup delay
	typedef struct {int gap; logic fault; logic [3:0] st;} wwsup_row_s;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, wdog_kick_in, ratio_select_0, ratio_select_1, supply_lockout;
	logic        rail_in_window, reset_delay_pin_oe, wdog_fault_oe, reset_out_n, irq;
	logic [3:0]  s_axi_wstrb;            // write lanes
	logic        dpin_out, fault_out_n;  // open-drain drive levels
	int          n_errors = 0;
	int          num_checks = 0;
	int          n;
	// kick gap, fault expected, status expected
	wwsup_row_s  rows [5] = '{'{64, 1'b0, 4'h0}, '{8, 1'b1, 4'h5}, '{24, 1'b0, 4'h0},
		'{120, 1'b0, 4'h0}, '{150, 1'b1, 4'h9}};
	// pullup strap on the delay pin
	wire logic   pin_in = !reset_delay_pin_oe;
	// ==========================================================
	// design and host
	wwsup_top #(.UPPER_CYC(UP), .DLY_OPEN_CYC(200), .DLY_PULL_CYC(DP)) dut_u (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.wdog_kick_in, .ratio_select_0, .ratio_select_1, .supply_lockout, .rail_in_window,
		.reset_delay_pin_in(pin_in), .reset_delay_pin_out(dpin_out), .reset_delay_pin_oe,
		.wdog_fault_out_n(fault_out_n), .wdog_fault_oe, .reset_out_n, .irq);
	wwsup_host host_u (.aclk, .wdog_kick_in);
	// ==========================================================
	// helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// count cycles until a level appears
	task automatic wait_lvl(ref logic s, input logic v);
		for (n = 0; s !== v && n < 6000; n++) @(posedge aclk);
	endtask
	// axi write, each channel released at its own handshake
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
		@(posedge aclk);
	endtask
	// axi read
	task automatic axi_rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		@(posedge aclk);
	endtask
	// verdict and end of run
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ==========================================================
	// clock and watchdog
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial
	begin
		#2000000;
		n_errors++;
		end_sim();
	end
	// ==========================================================
	// main sequence
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{ratio_select_0, ratio_select_1, supply_lockout, rail_in_window} = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("pulldown", 1'b1, reset_delay_pin_oe);
		axi_rd(8'h10);
		chk("unmapped", wwsup_pkg::RESP_SLVERR, rsp);
		axi_wr(wwsup_pkg::REG_MASK, 32'h4);
		chk("wresp", wwsup_pkg::RESP_OKAY, rsp);
		// low lane off: the mask write must be ignored
		s_axi_wstrb <= 4'he;
		axi_wr(wwsup_pkg::REG_MASK, 32'h0);
		s_axi_wstrb <= 4'hf;
		axi_rd(wwsup_pkg::REG_MASK);
		chk("mask lane", 32'h4, rd);
		chk("pin drive", 32'h0, {dpin_out, fault_out_n});
		repeat (2000) @(posedge aclk);
		chk("rail reset", 1'b0, reset_out_n);
		chk("rail fault", 1'b0, wdog_fault_oe);
		rail_in_window <= 1'b1;
		wait_lvl(reset_out_n, 1'b1);
		axi_rd(wwsup_pkg::REG_STATE);
		chk("option", 2'h1, rd[6:5]);
		axi_rd(wwsup_pkg::REG_STATUS);
		host_u.pulse(8);
		host_u.pulse(8);
		repeat (2960) @(posedge aclk);
		chk("setup", 1'b0, wdog_fault_oe);
		foreach (rows[i])
		begin
			host_u.pulse(64);
			host_u.pulse(rows[i].gap);
			repeat (8) @(posedge aclk);
			chk("fault", rows[i].fault, wdog_fault_oe);
			chk("irq", rows[i].st[2], irq);
			chk("reset", 1'b1, reset_out_n);
			if (rows[i].fault)
			begin
				wait_lvl(wdog_fault_oe, 1'b0);
				chk("hold", 1'b1, n >= 16 && n <= DP);
			end
			axi_rd(wwsup_pkg::REG_STATUS);
			chk("status", rows[i].st, rd[3:0]);
			chk("irq clear", 1'b0, irq);
		end
		ratio_select_0 <= 1'b1;
		repeat (300) @(posedge aclk);
		chk("disabled", 1'b0, wdog_fault_oe);
		ratio_select_0 <= 1'b0;
		wait_lvl(wdog_fault_oe, 1'b1);
		chk("late", 1'b1, n >= wwsup_pkg::SETUP_CYC + UP && n <= wwsup_pkg::SETUP_CYC + UP + 12);
		supply_lockout <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("lockout", 1'b0, reset_out_n);
		chk("fault off", 1'b0, wdog_fault_oe);
		chk("redetect", 1'b1, reset_delay_pin_oe);
		host_u.pulse(8);
		host_u.pulse(8);
		chk("ignored", 1'b0, wdog_fault_oe);
		// keep select changes of the two pins well apart
		repeat (7200) @(posedge aclk);
		ratio_select_1 <= 1'b1;
		supply_lockout <= 1'b0;
		wait_lvl(reset_out_n, 1'b1);
		chk("resume", 1'b1, reset_out_n);
		// a change while running must wait for the next reset
		ratio_select_1 <= 1'b0;
		axi_rd(wwsup_pkg::REG_STATE);
		chk("ratio", 2'h1, rd[8:7]);
		repeat (2990) @(posedge aclk);
		host_u.pulse(64);
		host_u.pulse(64);
		repeat (8) @(posedge aclk);
		chk("ratio early", 1'b1, wdog_fault_oe);
		end_sim();
	end
endmodule

/* verification/wwsup_host.sv */
// host model issuing watchdog kicks on the kick pin
module wwsup_host
(
	input  wire logic aclk,
	output logic      wdog_kick_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// kick pin
	// firmly driven high when idle
	initial wdog_kick_in = 1'b1;
	// falling edge lands gap - 4 cycles after the call, gap cycles after the previous pulse's edge, then 4 low cycles
	task automatic pulse(input int gap);
		repeat (gap - 4) @(posedge aclk);
		wdog_kick_in <= 1'b0;
		repeat (4) @(posedge aclk);
		wdog_kick_in <= 1'b1;
	endtask
endmodule

/* verilog/wwsup_pkg.sv */
// shared constants and types of the window watchdog supervisor
package wwsup_pkg;

	// ==========================================================
	// clock and derived cycle counts
	localparam int unsigned CLK_MHZ            = 20;     // aclk rate in MHz
	localparam int unsigned INIT_TIME_NS       = 81000;  // delay option detection, ns
	localparam int unsigned SETUP_TIME_NS      = 150000; // enable setup period, ns
	localparam int unsigned UPPER_WINDOW_US    = 1000;   // default upper window time, us
	localparam int unsigned RST_DELAY_OPEN_MS  = 200;    // open pin reset delay, ms
	localparam int unsigned RST_DELAY_PULL_MS  = 10;     // pullup reset delay, ms
	localparam int unsigned INIT_CYC  = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned SETUP_CYC = (SETUP_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned UPPER_WINDOW_CYC = UPPER_WINDOW_US * CLK_MHZ;
	localparam int unsigned RST_DELAY_OPEN_CYC = RST_DELAY_OPEN_MS * 1000 * CLK_MHZ;
	localparam int unsigned RST_DELAY_PULL_CYC = RST_DELAY_PULL_MS * 1000 * CLK_MHZ;
	localparam int unsigned PULL_CYC   = INIT_CYC / 2;        // pulldown phase of detection
	localparam int unsigned SAMPLE_CYC = INIT_CYC - PULL_CYC; // released phase of detection
	localparam int unsigned EARLY_CYC  = 4;                   // early pin sample point

	// ==========================================================
	// register map
	localparam logic [7:0] REG_CTRL   = 8'h00; // bit 0 software watchdog disable
	localparam logic [7:0] REG_STATUS = 8'h04; // sticky events, clear on read
	localparam logic [7:0] REG_MASK   = 8'h08; // interrupt mask, same layout
	localparam logic [7:0] REG_STATE  = 8'h0c; // live block state
	localparam int unsigned AXI_ADDR_W = 8;
	localparam int unsigned EV_W       = 4;
	localparam int unsigned EV_FAULT   = 0;    // fault output asserted
	localparam int unsigned EV_RESET   = 1;    // supervisor reset asserted
	localparam int unsigned EV_EARLY   = 2;    // kick before lower bound
	localparam int unsigned EV_LATE    = 3;    // no kick before upper bound
	localparam logic [EV_W-1:0] MASK_RST = 4'h0;
	localparam logic            CTRL_RST = 1'b0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// state types
	typedef enum logic [2:0] {WWSUP_RS_PULL, WWSUP_RS_SAMPLE, WWSUP_RS_HOLD,
		WWSUP_RS_DELAY, WWSUP_RS_RUN} wwsup_rs_e;
	typedef enum logic [2:0] {WWSUP_WD_OFF, WWSUP_WD_SETUP, WWSUP_WD_FIRST,
		WWSUP_WD_WINDOW, WWSUP_WD_FAULT} wwsup_wd_e;
	typedef enum logic [1:0] {WWSUP_OPT_CAP, WWSUP_OPT_PULLUP, WWSUP_OPT_OPEN} wwsup_opt_e;
	typedef enum logic [1:0] {WWSUP_RATIO_1_8, WWSUP_RATIO_3_4, WWSUP_RATIO_1_2} wwsup_ratio_e;

endpackage

/* verilog/wwsup_sync.sv */
// two flip-flop synchroniser for asynchronous pin levels
module wwsup_sync #(
	parameter int unsigned W = 1
) (
	input  logic         aclk,
	input  logic         aresetn,
	input  logic [W-1:0] d,
	output logic [W-1:0] q
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [W-1:0] s1; // first stage, read only by s2
		logic [W-1:0] s2; // stable copy
	} wwsup_sync_s;

	wwsup_sync_s st;
	wwsup_sync_s next_st;

	// shift the pin through both stages
	always_comb
	begin
		next_st    = st;
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end

	// register the copy
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign q = st.s2;
endmodule

/* verilog/wwsup_timer.sv */
// saturating cycle counter with synchronous clear
module wwsup_timer #(
	parameter int unsigned W = 32
) (
	input  logic         aclk,
	input  logic         aresetn,
	input  logic         clear,
	output logic [W-1:0] count
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [W-1:0] count; // cycles since last clear
	} wwsup_timer_s;

	wwsup_timer_s st;
	wwsup_timer_s next_st;

	// count up, hold at all ones
	always_comb
	begin
		next_st = st;
		if (clear)
			next_st.count = '0;
		else if (st.count != '1)
			next_st.count = st.count + W'(1);
	end

	// register the copy
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign count = st.count;
endmodule

/* verilog/wwsup_top.sv */
// window watchdog and reset supervision with an axi4-lite register slave

module wwsup_top #(
	parameter int unsigned UPPER_CYC     = wwsup_pkg::UPPER_WINDOW_CYC,
	parameter int unsigned DLY_OPEN_CYC  = wwsup_pkg::RST_DELAY_OPEN_CYC,
	parameter int unsigned DLY_PULL_CYC  = wwsup_pkg::RST_DELAY_PULL_CYC
) (
	input  logic                             aclk,
	input  logic                             aresetn,
	input  logic [wwsup_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  logic                             s_axi_awvalid,
	output logic                             s_axi_awready,
	input  logic [31:0]                      s_axi_wdata,
	input  logic [3:0]                       s_axi_wstrb,
	input  logic                             s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  logic                             s_axi_bready,
	input  logic [wwsup_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  logic                             s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  logic                             s_axi_rready,
	input  logic                             wdog_kick_in,
	input  logic                             ratio_select_0,
	input  logic                             ratio_select_1,
	input  logic                             supply_lockout,
	input  logic                             rail_in_window,
	input  logic                             reset_delay_pin_in,
	output logic                             reset_delay_pin_out,
	output logic                             reset_delay_pin_oe,
	output logic                             wdog_fault_out_n,
	output logic                             wdog_fault_oe,
	output logic                             reset_out_n,
	output logic                             irq
);
	// ==========================================================
	// elaboration checks
	if (UPPER_CYC < 16 || DLY_OPEN_CYC < 16 || DLY_PULL_CYC < 16)
		$error("window and delay counts must be at least 16 cycles");

	localparam logic [31:0] UPPER  = 32'(UPPER_CYC);
	localparam logic [31:0] D_OPEN = 32'(DLY_OPEN_CYC);
	localparam logic [31:0] D_PULL = 32'(DLY_PULL_CYC);

	// ==========================================================
	// state
	typedef struct packed {
		wwsup_pkg::wwsup_rs_e    rs;        // supervisor phase
		wwsup_pkg::wwsup_wd_e    wd;        // watchdog phase
		wwsup_pkg::wwsup_opt_e   opt;       // detected delay option
		wwsup_pkg::wwsup_ratio_e ratio;     // latched window ratio
		logic                    early_hi;  // pin high right after release
		logic [31:0]             cap_dly;   // measured capacitor delay
		logic                    kick_prev; // last synced kick level
		logic                    reset_n;   // supervisor reset level
		logic                    pd;        // delay pin pulldown on
		logic                    fault;     // fault output driven low
		logic                    ctrl_dis;  // software watchdog disable
		logic [wwsup_pkg::EV_W-1:0] status; // sticky events
		logic [wwsup_pkg::EV_W-1:0] mask;   // interrupt enables
		logic                    irq;       // interrupt level
		logic                    aw_have;   // write address held
		logic [wwsup_pkg::AXI_ADDR_W-1:0] awaddr;
		logic                    w_have;    // write data held
		logic [7:0]              wbyte;     // low byte of write data
		logic                    wlane;     // low byte lane strobed
		logic                    awready;
		logic                    wready;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    arready;
		logic                    rvalid;
		logic [1:0]              rresp;
		logic [31:0]             rdata;
	} wwsup_top_s;

	wwsup_top_s st;
	wwsup_top_s next_st;

	// ==========================================================
	// pin synchronisers and timers
	logic [5:0]  pins_s;   // synced pin levels
	logic        kick_s;   // synced kick
	logic        sel0_s;   // synced select 0
	logic        sel1_s;   // synced select 1
	logic        lock_s;   // synced supply lockout
	logic        rail_s;   // synced rail comparator
	logic        dpin_s;   // synced delay pin
	logic        clr_rs;   // restart supervisor timer
	logic        clr_wd;   // restart watchdog timer
	logic [31:0] t_rs;     // supervisor phase time
	logic [31:0] t_wd;     // watchdog interval time
	logic        kick_fall;
	logic        wd_en;
	logic        bad;
	logic [31:0] lower;
	logic [31:0] fault_dly;
	logic [wwsup_pkg::EV_W-1:0] ev;
	logic        rd_status;

	wwsup_sync #(.W(6)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({reset_delay_pin_in, rail_in_window, supply_lockout,
			ratio_select_1, ratio_select_0, wdog_kick_in}),
		.q       (pins_s)
	);
	assign {dpin_s, rail_s, lock_s, sel1_s, sel0_s, kick_s} = pins_s;

	wwsup_timer #(.W(32)) u_rs_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (clr_rs),
		.count   (t_rs)
	);
	wwsup_timer #(.W(32)) u_wd_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clear   (clr_wd),
		.count   (t_wd)
	);

	// ==========================================================
	// next state
	always_comb
	begin
		next_st   = st;
		clr_rs    = 1'b0;
		clr_wd    = 1'b0;
		ev        = '0;
		rd_status = 1'b0;
		// falling edge only; rising edges and levels do nothing
		kick_fall = st.kick_prev & ~kick_s;
		next_st.kick_prev = kick_s;
		// select 1/0 = 0/1 disables, software can also disable
		wd_en = ~(sel0_s & ~sel1_s) & ~st.ctrl_dis;
		bad   = lock_s | ~rail_s;
		// lower bound from latched ratio
		case (st.ratio)
			wwsup_pkg::WWSUP_RATIO_1_8: lower = UPPER >> 3;
			wwsup_pkg::WWSUP_RATIO_3_4: lower = UPPER - (UPPER >> 2);
			wwsup_pkg::WWSUP_RATIO_1_2: lower = UPPER >> 1;
			default:                    lower = UPPER >> 3;
		endcase
		// fault hold equals the reset delay of the detected option
		case (st.opt)
			wwsup_pkg::WWSUP_OPT_CAP:    fault_dly = st.cap_dly;
			wwsup_pkg::WWSUP_OPT_PULLUP: fault_dly = D_PULL;
			default:                     fault_dly = D_OPEN;
		endcase

		// supervisor sequence
		case (st.rs)
			// pull the delay pin low to discharge it
			wwsup_pkg::WWSUP_RS_PULL:
			begin
				next_st.pd = 1'b1;
				if (t_rs >= 32'(wwsup_pkg::PULL_CYC - 1))
				begin
					next_st.rs = wwsup_pkg::WWSUP_RS_SAMPLE;
					clr_rs     = 1'b1;
				end
			end
			// release and sample: fast high = pullup, late high = open
			wwsup_pkg::WWSUP_RS_SAMPLE:
			begin
				next_st.pd = 1'b0;
				if (t_rs == 32'(wwsup_pkg::EARLY_CYC))
					next_st.early_hi = dpin_s;
				if (t_rs >= 32'(wwsup_pkg::SAMPLE_CYC - 1))
				begin
					if (st.early_hi)
						next_st.opt = wwsup_pkg::WWSUP_OPT_PULLUP;
					else if (dpin_s)
						next_st.opt = wwsup_pkg::WWSUP_OPT_OPEN;
					else
						next_st.opt = wwsup_pkg::WWSUP_OPT_CAP;
					next_st.rs = wwsup_pkg::WWSUP_RS_HOLD;
				end
			end
			// hold while supply or rail is bad; latch the ratio here
			wwsup_pkg::WWSUP_RS_HOLD:
			begin
				next_st.pd = 1'b1;
				if (sel1_s && sel0_s)
					next_st.ratio = wwsup_pkg::WWSUP_RATIO_1_2;
				else if (sel1_s)
					next_st.ratio = wwsup_pkg::WWSUP_RATIO_3_4;
				else if (!sel0_s)
					next_st.ratio = wwsup_pkg::WWSUP_RATIO_1_8;
				if (!bad)
				begin
					next_st.rs = wwsup_pkg::WWSUP_RS_DELAY;
					clr_rs     = 1'b1;
				end
			end
			// reset delay: capacitor charges, else fixed count
			wwsup_pkg::WWSUP_RS_DELAY:
			begin
				next_st.pd = 1'b0;
				if (bad)
					next_st.rs = wwsup_pkg::WWSUP_RS_HOLD;
				else if (st.opt == wwsup_pkg::WWSUP_OPT_CAP ? dpin_s
					: (t_rs >= fault_dly - 32'h1))
				begin
					next_st.rs = wwsup_pkg::WWSUP_RS_RUN;
					if (st.opt == wwsup_pkg::WWSUP_OPT_CAP)
						next_st.cap_dly = (t_rs < 32'h10) ? 32'h10 : t_rs;
				end
			end
			// running: any bad condition restarts detection
			wwsup_pkg::WWSUP_RS_RUN:
			begin
				next_st.pd = 1'b0;
				if (bad)
				begin
					next_st.rs    = wwsup_pkg::WWSUP_RS_PULL;
					next_st.pd    = 1'b1; // pulldown starts with the reset
					clr_rs        = 1'b1;
					ev[wwsup_pkg::EV_RESET] = 1'b1;
				end
			end
			default:
			begin
				next_st.rs = wwsup_pkg::WWSUP_RS_PULL;
				clr_rs     = 1'b1;
			end
		endcase
		next_st.reset_n = (next_st.rs == wwsup_pkg::WWSUP_RS_RUN);

		// watchdog, off while reset is asserted or disabled
		if (!next_st.reset_n || !wd_en)
		begin
			next_st.wd = wwsup_pkg::WWSUP_WD_OFF;
			clr_wd     = 1'b1;
		end
		else
		begin
			case (st.wd)
				// resume after reset release or enable
				wwsup_pkg::WWSUP_WD_OFF:
				begin
					next_st.wd = wwsup_pkg::WWSUP_WD_SETUP;
					clr_wd     = 1'b1;
				end
				// kicks ignored during setup
				wwsup_pkg::WWSUP_WD_SETUP:
				begin
					if (t_wd >= 32'(wwsup_pkg::SETUP_CYC - 1))
					begin
						next_st.wd = wwsup_pkg::WWSUP_WD_FIRST;
						clr_wd     = 1'b1;
					end
				end
				// first kick: upper bound only
				wwsup_pkg::WWSUP_WD_FIRST:
				begin
					if (kick_fall && t_wd < UPPER)
					begin
						next_st.wd = wwsup_pkg::WWSUP_WD_WINDOW;
						clr_wd     = 1'b1;
					end
					else if (t_wd >= UPPER)
					begin
						next_st.wd = wwsup_pkg::WWSUP_WD_FAULT;
						clr_wd     = 1'b1;
						ev[wwsup_pkg::EV_LATE] = 1'b1;
					end
				end
				// later kicks: both bounds
				wwsup_pkg::WWSUP_WD_WINDOW:
				begin
					if (kick_fall && t_wd < lower)
					begin
						next_st.wd = wwsup_pkg::WWSUP_WD_FAULT;
						clr_wd     = 1'b1;
						ev[wwsup_pkg::EV_EARLY] = 1'b1;
					end
					else if (kick_fall && t_wd < UPPER)
						clr_wd = 1'b1;
					else if (t_wd >= UPPER)
					begin
						next_st.wd = wwsup_pkg::WWSUP_WD_FAULT;
						clr_wd     = 1'b1;
						ev[wwsup_pkg::EV_LATE] = 1'b1;
					end
				end
				// hold the fault for the reset delay, then restart
				wwsup_pkg::WWSUP_WD_FAULT:
				begin
					if (t_wd >= fault_dly - 32'h1)
					begin
						next_st.wd = wwsup_pkg::WWSUP_WD_FIRST;
						clr_wd     = 1'b1;
					end
				end
				default:
				begin
					next_st.wd = wwsup_pkg::WWSUP_WD_OFF;
					clr_wd     = 1'b1;
				end
			endcase
		end
		// fault pin is separate from reset, released while reset is low
		next_st.fault = (next_st.wd == wwsup_pkg::WWSUP_WD_FAULT);
		if (next_st.fault && !st.fault)
			ev[wwsup_pkg::EV_FAULT] = 1'b1;

		// write channel: address and data in either order
		if (s_axi_awvalid && st.awready)
		begin
			next_st.aw_have = 1'b1;
			next_st.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.wready)
		begin
			next_st.w_have = 1'b1;
			next_st.wbyte  = s_axi_wdata[7:0];
			next_st.wlane  = s_axi_wstrb[0];
		end
		if (st.bvalid && s_axi_bready)
			next_st.bvalid = 1'b0;
		if (st.aw_have && st.w_have && !st.bvalid)
		begin
			next_st.aw_have = 1'b0;
			next_st.w_have  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = wwsup_pkg::RESP_OKAY;
			case (st.awaddr)
				wwsup_pkg::REG_CTRL:
					if (st.wlane)
						next_st.ctrl_dis = st.wbyte[0];
				wwsup_pkg::REG_MASK:
					if (st.wlane)
						next_st.mask = st.wbyte[wwsup_pkg::EV_W-1:0];
				wwsup_pkg::REG_STATUS, wwsup_pkg::REG_STATE: ; // read only, ignored
				default:
					next_st.bresp = wwsup_pkg::RESP_SLVERR;
			endcase
		end
		next_st.awready = ~next_st.aw_have & ~next_st.bvalid;
		next_st.wready  = ~next_st.w_have & ~next_st.bvalid;

		// read channel: one cycle to data
		if (st.rvalid && s_axi_rready)
			next_st.rvalid = 1'b0;
		if (s_axi_arvalid && st.arready)
		begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = wwsup_pkg::RESP_OKAY;
			next_st.rdata  = '0;
			case (s_axi_araddr)
				wwsup_pkg::REG_CTRL:   next_st.rdata[0] = st.ctrl_dis;
				wwsup_pkg::REG_STATUS:
				begin
					next_st.rdata[wwsup_pkg::EV_W-1:0] = st.status;
					rd_status = 1'b1;
				end
				wwsup_pkg::REG_MASK:   next_st.rdata[wwsup_pkg::EV_W-1:0] = st.mask;
				wwsup_pkg::REG_STATE:
					next_st.rdata[8:0] = {st.ratio, st.opt, st.wd, st.fault, st.reset_n};
				default:               next_st.rresp = wwsup_pkg::RESP_SLVERR;
			endcase
		end
		next_st.arready = ~next_st.rvalid;

		// sticky status: a new event wins over the read clear
		next_st.status = (rd_status ? '0 : st.status) | ev;
		next_st.irq    = |(next_st.status & st.mask);
	end

	// ==========================================================
	// state register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st          <= '0;
			st.rs       <= wwsup_pkg::WWSUP_RS_PULL;
			st.wd       <= wwsup_pkg::WWSUP_WD_OFF;
			st.opt      <= wwsup_pkg::WWSUP_OPT_OPEN;
			st.ratio    <= wwsup_pkg::WWSUP_RATIO_1_8;
			st.cap_dly  <= D_PULL;
			st.mask     <= wwsup_pkg::MASK_RST;
			st.ctrl_dis <= wwsup_pkg::CTRL_RST;
			st.pd       <= 1'b1;
		end
		else
			st <= next_st;
	end

	// ==========================================================
	// outputs from the state register; the delay pin and fault pin drive levels are tied low
	assign s_axi_awready       = st.awready;
	assign s_axi_wready        = st.wready;
	assign s_axi_bvalid        = st.bvalid;
	assign s_axi_bresp         = st.bresp;
	assign s_axi_arready       = st.arready;
	assign s_axi_rvalid        = st.rvalid;
	assign s_axi_rresp         = st.rresp;
	assign s_axi_rdata         = st.rdata;
	assign reset_delay_pin_out = 1'b0;
	assign reset_delay_pin_oe  = st.pd;
	assign wdog_fault_out_n    = 1'b0;
	assign wdog_fault_oe       = st.fault;
	assign reset_out_n         = st.reset_n;
	assign irq                 = st.irq;

	// ==========================================================
	// assertions
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_rise_no_kick: assert property (
		(st.wd == wwsup_pkg::WWSUP_WD_WINDOW && !st.kick_prev && kick_s && t_wd < lower
		&& wd_en && !bad) |=> st.wd == wwsup_pkg::WWSUP_WD_WINDOW && t_wd != 32'h0)
		else $error("rising kick edge was taken as a kick");
	a_first_late: assert property (
		(st.wd == wwsup_pkg::WWSUP_WD_FIRST && t_wd >= UPPER && !kick_fall && wd_en && !bad)
		|=> wdog_fault_oe)
		else $error("missing first kick did not raise fault");
	a_window_good: assert property (
		(st.wd == wwsup_pkg::WWSUP_WD_WINDOW && kick_fall && t_wd >= lower && t_wd < UPPER
		&& wd_en && !bad) |=> !wdog_fault_oe ##1 t_wd == 32'h1)
		else $error("in-window kick did not restart timer cleanly");
	a_early_kick: assert property (
		(st.wd == wwsup_pkg::WWSUP_WD_WINDOW && kick_fall && t_wd < lower && wd_en && !bad)
		|=> wdog_fault_oe && st.status[wwsup_pkg::EV_EARLY])
		else $error("early kick did not raise fault");
	a_reset_frees: assert property (
		!reset_out_n |-> !wdog_fault_oe && st.wd == wwsup_pkg::WWSUP_WD_OFF)
		else $error("fault driven or watchdog active during reset");
	a_lockout_rst: assert property (
		lock_s |=> !reset_out_n)
		else $error("supply lockout did not hold reset");
	a_detect_pd: assert property (
		$fell(reset_out_n) |-> reset_delay_pin_oe ##1 reset_delay_pin_oe)
		else $error("detection did not start with pulldown");
	a_setup_hold: assert property (
		(st.wd == wwsup_pkg::WWSUP_WD_OFF && next_st.wd == wwsup_pkg::WWSUP_WD_SETUP)
		|=> (st.wd == wwsup_pkg::WWSUP_WD_SETUP || !wd_en || !reset_out_n)[*8])
		else $error("setup period ended early");
	a_fault_hold: assert property (
		($rose(wdog_fault_oe) && reset_out_n && wd_en)
		|-> ((wdog_fault_oe || !reset_out_n || !wd_en)[*8]))
		else $error("fault released before reset delay");

	c_fault:   cover property ($rose(wdog_fault_oe));
	c_good:    cover property (st.wd == wwsup_pkg::WWSUP_WD_WINDOW && kick_fall && clr_wd
		&& next_st.wd == wwsup_pkg::WWSUP_WD_WINDOW);
	c_release: cover property ($rose(reset_out_n));
	c_irq:     cover property ($rose(irq));
endmodule
